// File: src/capture_filter.sv
// trigger synchroniser, four-sample noise filter and edge detector
`timescale 1ns/10ps
`include "timer16_params.svh"
module capture_filter (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic clk_enable, // freezes state while low
  capture_trigger_if.filter trig // trigger path to the core
);
  timer16_pkg::filter_state_type s, next;
  logic src;

  // both sources are synchronised all the time, so switching may fake an edge
  assign src = trig.cmp_select ? s.cmp_sync[1] : s.pin_sync[1];

  always_comb begin
    next = s;
    next.pin_sync = {s.pin_sync[0], trig.pin_level};
    next.cmp_sync = {s.cmp_sync[0], trig.cmp_level};
    next.history = {s.history[`FILTER_SAMPLES-2:0], src};
    if (!trig.filter_enable) begin
      next.level = src;
    end else if ((&s.history) || !(|s.history)) begin
      next.level = s.history[`FILTER_SAMPLES-1];
    end
    next.prev_level = s.level;
    next.event_pulse = trig.enable && (s.level != s.prev_level) && (s.level == trig.edge_select);
  end

  assign trig.capture_event = s.event_pulse;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (clk_enable) begin
      s <= next;
    end
  end

  chk_filter_all_agree: assert property (@(posedge clk) disable iff (!resetn)
    (trig.filter_enable && $past(trig.filter_enable) && $past(clk_enable) && s.level != $past(s.level))
    |-> ($past(s.history) == {`FILTER_SAMPLES{s.level}}))
    else $error("filter output moved without four equal samples");
endmodule

// File: src/capture_trigger_if.sv
// trigger path between the core and the capture filter
`timescale 1ns/10ps
interface capture_trigger_if;
  logic pin_level;
  logic cmp_level;
  logic cmp_select;
  logic filter_enable;
  logic edge_select;
  logic enable;
  logic capture_event;
  modport core (output pin_level, cmp_level, cmp_select, filter_enable, edge_select, enable,
                input capture_event);
  modport filter (input pin_level, cmp_level, cmp_select, filter_enable, edge_select, enable,
                  output capture_event);
endinterface

// File: src/tick_generator.sv
// timer tick source: stop, system clock, prescaled taps or external pin edges
`timescale 1ns/10ps
`include "timer16_params.svh"
module tick_generator #(
  parameter int DIV_A = 4,
  parameter int DIV_B = 16,
  parameter int DIV_C = 64,
  parameter int DIV_D = 256
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset, active low
  input wire logic clk_enable, // freezes state while low
  input wire logic [2:0] clock_source_select, // tick source code
  input wire logic external_tick_pin, // asynchronous pin
  output logic timer_tick // one-cycle tick
);
  localparam logic [9:0] MASK_A = 10'(DIV_A - 1);
  localparam logic [9:0] MASK_B = 10'(DIV_B - 1);
  localparam logic [9:0] MASK_C = 10'(DIV_C - 1);
  localparam logic [9:0] MASK_D = 10'(DIV_D - 1);
  timer16_pkg::tick_state_type s, next;

  always_comb begin
    next = s;
    next.prescale = s.prescale + 10'h001;
    next.ext_sync = {s.ext_sync[0], external_tick_pin};
    next.ext_prev = s.ext_sync[1];
  end

  always_comb begin
    case (clock_source_select)
      3'h0: timer_tick = 1'b0;
      3'h1: timer_tick = clk_enable;
      3'h2: timer_tick = clk_enable && ((s.prescale & MASK_A) == MASK_A);
      3'h3: timer_tick = clk_enable && ((s.prescale & MASK_B) == MASK_B);
      3'h4: timer_tick = clk_enable && ((s.prescale & MASK_C) == MASK_C);
      3'h5: timer_tick = clk_enable && ((s.prescale & MASK_D) == MASK_D);
      3'h6: timer_tick = clk_enable && s.ext_prev && !s.ext_sync[1];
      default: timer_tick = clk_enable && !s.ext_prev && s.ext_sync[1];
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (clk_enable) begin
      s <= next;
    end
  end
endmodule

// File: src/timer16_capture_core.sv
// 16-bit timer counter with shared high byte and input capture, AXI4-Lite registers
// How it works
// - select code zero stops the counter
// - software count write beats any counter step
// - count bytes share one high holding byte
// - count access works with tick stopped
// - each tick clears, increments or decrements once
// - waveform mode field sets count sequence
// - overflow flag set where mode defines
// - chosen filtered edge copies count to capture
// - capture flag set with store, irq enabled
// - flag clears on service or written one
// - capture low read loads holding byte
// - capture writable only in capture-top modes
// - comparator select routes comparator as trigger
// - software clears flag after source change
// - triggers synchronised; filter adds four cycles
// - no captures in capture-top modes
// - pin driven by own port still captures
// - filter changes after four equal samples
// - filter enable bit, samples system clock
// - new capture overwrites unread value
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "timer16_params.svh"
module timer16_capture_core (
  input wire logic clk, // system clock, 100 MHz
  input wire logic resetn, // async reset, active low
  input wire logic clk_enable, // freezes all state while low
  input wire logic [7:0] awaddr, // write address
  input wire logic [2:0] awprot, // unused
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data, low byte used
  input wire logic [3:0] wstrb, // byte lanes, lane 0 used
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic [2:0] arprot, // unused
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic capture_pin, // asynchronous capture input
  input wire logic comparator_output, // asynchronous comparator level
  input wire logic external_tick_pin, // asynchronous external tick
  input wire logic capture_irq_ack, // capture interrupt serviced pulse
  input wire logic overflow_irq_ack, // overflow interrupt serviced pulse
  output logic capture_irq, // capture interrupt request
  output logic overflow_irq, // overflow interrupt request
  output logic at_top, // count equals top
  output logic at_bottom // count equals zero
);
  timer16_pkg::core_state_type s, next;
  logic timer_tick;
  logic [3:0] mode;
  logic [15:0] top;
  logic icr_top;
  logic dual;
  logic ctc;
  logic count_wr;
  logic temp_wr;
  logic cap_wr;
  logic cap_clr;
  logic cap_set;
  logic ovf_clr;
  logic ovf_set;
  capture_trigger_if trig();

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  assign mode = {s.control_b[`CB_WGM_LSB +: 2], s.control_a[`CA_WGM_LSB +: 2]};

  always_comb begin
    case (timer16_pkg::wave_mode_type'(mode))
      timer16_pkg::mode_pc8, timer16_pkg::mode_fast8: top = `TOP_8BIT;
      timer16_pkg::mode_pc9, timer16_pkg::mode_fast9: top = `TOP_9BIT;
      timer16_pkg::mode_pc10, timer16_pkg::mode_fast10: top = `TOP_10BIT;
      timer16_pkg::mode_pfc_icr, timer16_pkg::mode_pc_icr,
      timer16_pkg::mode_ctc_icr, timer16_pkg::mode_fast_icr: top = s.capture;
      default: top = `TOP_MAX;
    endcase
  end

  assign icr_top = (mode == timer16_pkg::mode_pfc_icr) || (mode == timer16_pkg::mode_pc_icr) ||
                   (mode == timer16_pkg::mode_ctc_icr) || (mode == timer16_pkg::mode_fast_icr);
  assign dual = (mode == timer16_pkg::mode_pc8) || (mode == timer16_pkg::mode_pc9) ||
                (mode == timer16_pkg::mode_pc10) || (mode == timer16_pkg::mode_pfc_icr) ||
                (mode == timer16_pkg::mode_pfc_ocr) || (mode == timer16_pkg::mode_pc_icr) ||
                (mode == timer16_pkg::mode_pc_ocr);
  assign ctc = (mode == timer16_pkg::mode_ctc_ocr) || (mode == timer16_pkg::mode_ctc_icr);

  ////////////////////////////////////////////////////////////////////////////
  // tick source and trigger path

  tick_generator u_tick (
    .clk(clk),
    .resetn(resetn),
    .clk_enable(clk_enable),
    .clock_source_select(s.control_b[`CB_CS_LSB +: 3]),
    .external_tick_pin(external_tick_pin),
    .timer_tick(timer_tick)
  );

  // a pin toggled by its own port driver arrives here like any outside edge
  assign trig.pin_level = capture_pin;
  assign trig.cmp_level = comparator_output;
  assign trig.cmp_select = s.comparator_control[`CMP_SELECT_BIT];
  assign trig.filter_enable = s.control_b[`CB_FILTER_BIT];
  assign trig.edge_select = s.control_b[`CB_EDGE_BIT];
  assign trig.enable = !icr_top;

  capture_filter u_filter (
    .clk(clk),
    .resetn(resetn),
    .clk_enable(clk_enable),
    .trig(trig)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes and outputs

  // readiness is withheld while frozen so no beat is lost
  assign awready = clk_enable && !s.aw_held && !s.bvalid;
  assign wready = clk_enable && !s.w_held && !s.bvalid;
  assign arready = clk_enable && !s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign capture_irq = s.capture_flag && s.irq_mask[`FLAG_CAPTURE_BIT];
  assign overflow_irq = s.overflow_flag && s.irq_mask[`FLAG_OVERFLOW_BIT];
  assign at_top = (s.count == top);
  assign at_bottom = (s.count == `RESET_WORD);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [7:0] rd;
    rd = `RESET_BYTE;
    next = s;
    count_wr = 1'b0;
    temp_wr = 1'b0;
    cap_wr = 1'b0;
    cap_set = 1'b0;
    ovf_set = 1'b0;
    cap_clr = capture_irq_ack;
    ovf_clr = overflow_irq_ack;

    // counter step; a same-cycle software write below overrides it
    if (timer_tick) begin
      if (dual) begin
        if (s.count_up) begin
          if (s.count >= top) begin
            next.count_up = 1'b0;
            next.count = s.count - 16'h0001;
          end else begin
            next.count = s.count + 16'h0001;
          end
        end else if (s.count == `RESET_WORD) begin
          next.count_up = 1'b1;
          next.count = s.count + 16'h0001;
        end else begin
          next.count = s.count - 16'h0001;
          ovf_set = (s.count == 16'h0001);
        end
      end else begin
        next.count_up = 1'b1;
        ovf_set = (s.count == `TOP_MAX) || ((s.count == top) && !ctc);
        if (s.count == top) begin
          next.count = `RESET_WORD;
        end else begin
          next.count = s.count + 16'h0001;
        end
      end
    end

    // an unread capture is simply overwritten
    if (trig.capture_event && !icr_top) begin
      next.capture = s.count;
      cap_set = 1'b1;
    end

    if (s.rvalid && rready) begin
      next.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next.rvalid = 1'b1;
      next.rresp = `RESP_OKAY;
      if (araddr == `OFS_CONTROL_A) begin
        rd = s.control_a;
      end else if (araddr == `OFS_CONTROL_B) begin
        rd = s.control_b;
      end else if (araddr == `OFS_COUNT_LOW) begin
        rd = s.count[7:0];
        next.temp = s.count[15:8];
      end else if (araddr == `OFS_COUNT_HIGH || araddr == `OFS_CAPTURE_HIGH) begin
        rd = s.temp;
      end else if (araddr == `OFS_CAPTURE_LOW) begin
        rd = s.capture[7:0];
        next.temp = s.capture[15:8];
      end else if (araddr == `OFS_FLAGS) begin
        rd[`FLAG_CAPTURE_BIT] = s.capture_flag;
        rd[`FLAG_OVERFLOW_BIT] = s.overflow_flag;
      end else if (araddr == `OFS_IRQ_MASK) begin
        rd = s.irq_mask;
      end else if (araddr == `OFS_COMPARATOR) begin
        rd = s.comparator_control;
      end else begin
        next.rresp = `RESP_SLVERR;
      end
      next.rdata = {24'h000000, rd};
    end

    if (awvalid && awready) begin
      next.aw_held = 1'b1;
      next.awaddr = awaddr;
    end
    if (wvalid && wready) begin
      next.w_held = 1'b1;
      next.wdata = wdata[7:0];
      next.wstrb0 = wstrb[0];
    end
    if (s.bvalid && bready) begin
      next.bvalid = 1'b0;
    end
    // commit once address and data are both held, in whichever order they came
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next.aw_held = 1'b0;
      next.w_held = 1'b0;
      next.bvalid = 1'b1;
      next.bresp = `RESP_OKAY;
      if (s.awaddr == `OFS_CONTROL_A) begin
        if (s.wstrb0) next.control_a = s.wdata;
      end else if (s.awaddr == `OFS_CONTROL_B) begin
        if (s.wstrb0) next.control_b = s.wdata;
      end else if (s.awaddr == `OFS_COUNT_LOW) begin
        if (s.wstrb0) begin
          next.count = {s.temp, s.wdata};
          count_wr = 1'b1;
        end
      end else if (s.awaddr == `OFS_COUNT_HIGH || s.awaddr == `OFS_CAPTURE_HIGH) begin
        if (s.wstrb0) begin
          next.temp = s.wdata;
          temp_wr = 1'b1;
        end
      end else if (s.awaddr == `OFS_CAPTURE_LOW) begin
        if (s.wstrb0 && icr_top) begin
          next.capture = {s.temp, s.wdata};
          cap_wr = 1'b1;
        end
      end else if (s.awaddr == `OFS_FLAGS) begin
        if (s.wstrb0) begin
          cap_clr = cap_clr || s.wdata[`FLAG_CAPTURE_BIT];
          ovf_clr = ovf_clr || s.wdata[`FLAG_OVERFLOW_BIT];
        end
      end else if (s.awaddr == `OFS_IRQ_MASK) begin
        if (s.wstrb0) next.irq_mask = s.wdata;
      end else if (s.awaddr == `OFS_COMPARATOR) begin
        if (s.wstrb0) next.comparator_control = s.wdata;
      end else begin
        next.bresp = `RESP_SLVERR;
      end
    end

    // a new event in the clearing cycle is kept
    next.capture_flag = (s.capture_flag && !cap_clr) || cap_set;
    next.overflow_flag = (s.overflow_flag && !ovf_clr) || ovf_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else if (clk_enable) begin
      s <= next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  chk_stopped_count_holds: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && s.control_b[`CB_CS_LSB +: 3] == 3'h0 && !count_wr) |=> (s.count == $past(s.count)))
    else $error("counter moved with no tick source");

  chk_count_write_wins: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && count_wr) |=> (s.count == {$past(s.temp), $past(s.wdata)}))
    else $error("count write lost to a counter step");

  chk_low_read_temp: assert property (@(posedge clk) disable iff (!resetn)
    (arvalid && arready && araddr == `OFS_COUNT_LOW && !temp_wr)
    |=> (s.temp == $past(s.count[15:8])) && rvalid && (rdata[7:0] == $past(s.count[7:0])))
    else $error("count low read did not load holding byte");

  chk_step_by_one: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && timer_tick && !count_wr)
    |=> (s.count == $past(s.count) + 16'h0001 || s.count == $past(s.count) - 16'h0001 ||
         s.count == `RESET_WORD))
    else $error("counter step was not clear or one");

  chk_capture_copies: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && trig.capture_event && !icr_top)
    |=> (s.capture == $past(s.count) && s.capture_flag))
    else $error("capture did not store count with flag");

  chk_capture_irq_raise: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && trig.capture_event && !icr_top &&
     next.irq_mask[`FLAG_CAPTURE_BIT]) |=> capture_irq)
    else $error("enabled capture did not request interrupt");

  chk_flag_write_clear: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && cap_clr && !cap_set) |=> !s.capture_flag)
    else $error("capture flag not cleared");

  chk_no_capture_icr_top: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && icr_top && !cap_wr) |=> (s.capture == $past(s.capture)))
    else $error("capture value changed in capture-top mode");

  chk_cap_read_temp: assert property (@(posedge clk) disable iff (!resetn)
    (arvalid && arready && araddr == `OFS_CAPTURE_LOW && !temp_wr)
    |=> (s.temp == $past(s.capture[15:8])))
    else $error("capture low read did not load holding byte");

  chk_overflow_at_max: assert property (@(posedge clk) disable iff (!resetn)
    (clk_enable && timer_tick && mode == timer16_pkg::mode_normal && s.count == `TOP_MAX)
    |=> (s.overflow_flag && (count_wr || s.count == `RESET_WORD || $past(count_wr))))
    else $error("overflow not flagged at wrap");
endmodule

// File: src/timer16_params.svh
// offsets, field positions, reset values and counts of the 16-bit timer core
`ifndef TIMER16_PARAMS_SVH
`define TIMER16_PARAMS_SVH
`define OFS_CONTROL_A 8'h00
`define OFS_CONTROL_B 8'h04
`define OFS_COUNT_LOW 8'h08
`define OFS_COUNT_HIGH 8'h0C
`define OFS_CAPTURE_LOW 8'h10
`define OFS_CAPTURE_HIGH 8'h14
`define OFS_FLAGS 8'h18
`define OFS_IRQ_MASK 8'h1C
`define OFS_COMPARATOR 8'h20
`define CA_WGM_LSB 0
`define CB_CS_LSB 0
`define CB_WGM_LSB 3
`define CB_EDGE_BIT 6
`define CB_FILTER_BIT 7
`define FLAG_CAPTURE_BIT 0
`define FLAG_OVERFLOW_BIT 1
`define CMP_SELECT_BIT 2
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define TOP_8BIT 16'h00FF
`define TOP_9BIT 16'h01FF
`define TOP_10BIT 16'h03FF
`define TOP_MAX 16'hFFFF
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define FILTER_SAMPLES 4
`endif

// File: src/timer16_pkg.sv
// types shared by the timer core modules
package timer16_pkg;
  typedef enum logic [3:0] {
    mode_normal = 4'b0000, mode_pc8 = 4'b0001, mode_pc9 = 4'b0010, mode_pc10 = 4'b0011,
    mode_ctc_ocr = 4'b0100, mode_fast8 = 4'b0101, mode_fast9 = 4'b0110, mode_fast10 = 4'b0111,
    mode_pfc_icr = 4'b1000, mode_pfc_ocr = 4'b1001, mode_pc_icr = 4'b1010, mode_pc_ocr = 4'b1011,
    mode_ctc_icr = 4'b1100, mode_reserved = 4'b1101, mode_fast_icr = 4'b1110, mode_fast_ocr = 4'b1111
  } wave_mode_type;
  typedef struct packed {
    logic [7:0] control_a;
    logic [7:0] control_b;
    logic [7:0] comparator_control;
    logic [7:0] irq_mask;
    logic [7:0] temp;
    logic [15:0] count;
    logic count_up;
    logic [15:0] capture;
    logic capture_flag;
    logic overflow_flag;
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } core_state_type;
  typedef struct packed {
    logic [9:0] prescale;
    logic [1:0] ext_sync;
    logic ext_prev;
  } tick_state_type;
  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] cmp_sync;
    logic [3:0] history;
    logic level;
    logic prev_level;
    logic event_pulse;
  } filter_state_type;
endpackage

// File: tb/test_timer16_counter_input_capture.sv
// self-checking bench of the timer core over AXI4-Lite
`timescale 1ns/10ps
module test_timer16_counter_input_capture;
  logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic capture_pin, comparator_output, external_tick_pin, capture_irq_ack, overflow_irq_ack;
  logic capture_irq, overflow_irq, at_top, at_bottom;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [33:0] expq[$];
  logic [15:0] val;
  int n_mismatch, samples_checked, cycles, i;
  timer16_capture_core dut (.clk(clk), .resetn(resetn), .clk_enable(1'b1), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_pin(capture_pin), .comparator_output(comparator_output), .external_tick_pin(external_tick_pin),
    .capture_irq_ack(capture_irq_ack), .overflow_irq_ack(overflow_irq_ack), .capture_irq(capture_irq),
    .overflow_irq(overflow_irq), .at_top(at_top), .at_bottom(at_bottom));
  trigger_source src (.clk(clk), .capture_pin(capture_pin), .comparator_output(comparator_output),
    .external_tick_pin(external_tick_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [33:0] seen, input logic [33:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, expected, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  // the expected word is queued before the request goes out
  task automatic rd(input logic [7:0] a, input logic [1:0] resp, input logic [7:0] b);
    expq.push_back({resp, 24'h000000, b});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
  endtask
  always @(posedge clk) begin
    if (rvalid && rready) check("read word", {rresp, rdata}, expq.pop_front());
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, capture_irq_ack, overflow_irq_ack} = 8'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {n_mismatch, samples_checked, cycles} = 0;
    void'($urandom(32'hAA73372A));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h08, 2'b00, 8'h00);
    rd(8'h10, 2'b00, 8'h00);
    rd(8'h18, 2'b00, 8'h00);
    rd(8'h24, 2'b10, 8'h00);
    check("bottom", at_bottom, 1'b1);
    wr(8'h0C, 8'h12);
    wr(8'h08, 8'h34);
    repeat (20) @(posedge clk);
    rd(8'h08, 2'b00, 8'h34);
    rd(8'h0C, 2'b00, 8'h12);
    $display("reset and stopped count done");
    wr(8'h1C, 8'h01);
    for (i = 0; i < 4; i++) begin
      val = 16'($urandom);
      wr(8'h0C, val[15:8]);
      wr(8'h08, val[7:0]);
      wr(8'h04, {1'b0, i[0], 6'h00});
      src.pulse(1'b0, !i[0], 0);
      repeat (12) @(posedge clk);
      wr(8'h18, 8'h01);
      check("flag cleared", capture_irq, 1'b0);
      src.pulse(1'b0, i[0], 0);
      repeat (12) @(posedge clk);
      check("capture irq", capture_irq, 1'b1);
      wr(8'h18, 8'h00);
      rd(8'h10, 2'b00, val[7:0]);
      rd(8'h14, 2'b00, val[15:8]);
      rd(8'h18, 2'b00, 8'h01);
    end
    capture_irq_ack <= 1'b1;
    @(posedge clk);
    capture_irq_ack <= 1'b0;
    rd(8'h18, 2'b00, 8'h00);
    $display("capture edges done");
    wr(8'h04, 8'hC0);
    src.pulse(1'b0, 1'b0, 0);
    repeat (12) @(posedge clk);
    wr(8'h18, 8'h01);
    src.pulse(1'b0, 1'b1, 3);
    repeat (15) @(posedge clk);
    check("glitch", capture_irq, 1'b0);
    src.pulse(1'b0, 1'b1, 0);
    repeat (9) @(posedge clk);
    check("filter delay", capture_irq, 1'b0);
    @(posedge clk);
    check("filtered capture", capture_irq, 1'b1);
    wr(8'h04, 8'h40);
    wr(8'h20, 8'h04);
    repeat (12) @(posedge clk);
    wr(8'h18, 8'h01);
    src.pulse(1'b1, 1'b1, 0);
    repeat (12) @(posedge clk);
    check("comparator capture", capture_irq, 1'b1);
    $display("filter and comparator done");
    wr(8'h20, 8'h00);
    wr(8'h04, 8'h18);
    wr(8'h18, 8'h01);
    wr(8'h14, 8'hAB);
    wr(8'h10, 8'hCD);
    // one holding byte serves both low writes
    wr(8'h08, 8'hCD);
    check("count at top", at_top, 1'b1);
    rd(8'h10, 2'b00, 8'hCD);
    rd(8'h14, 2'b00, 8'hAB);
    src.pulse(1'b0, 1'b0, 0);
    repeat (12) @(posedge clk);
    check("no capture at top mode", capture_irq, 1'b0);
    // count from near the wrap so overflow lands well inside the wait
    wr(8'h04, 8'h00);
    wr(8'h0C, 8'hFF);
    wr(8'h08, 8'hF0);
    wr(8'h18, 8'h03);
    wr(8'h1C, 8'h02);
    wr(8'h04, 8'h01);
    repeat (40) @(posedge clk);
    check("overflow irq", overflow_irq, 1'b1);
    wr(8'h04, 8'h00);
    overflow_irq_ack <= 1'b1;
    @(posedge clk);
    overflow_irq_ack <= 1'b0;
    rd(8'h18, 2'b00, 8'h00);
    // dual slope: up to the fixed top, back down, overflow on reaching zero
    wr(8'h00, 8'h01);
    wr(8'h0C, 8'h00);
    wr(8'h08, 8'hFD);
    wr(8'h04, 8'h01);
    repeat (300) @(posedge clk);
    rd(8'h18, 2'b00, 8'h02);
    $display("counting done");
    test_done();
  end
endmodule

// File: tb/trigger_source.sv
// pin-side model: capture pin, comparator level and a free external tick
`timescale 1ns/10ps
module trigger_source (
  input wire logic clk, // system clock
  output logic capture_pin, // capture input level
  output logic comparator_output, // comparator level
  output logic external_tick_pin // free running tick pin
);
  logic [1:0] div;
  initial begin
    capture_pin = 1'b0;
    comparator_output = 1'b0;
    external_tick_pin = 1'b0;
    div = 2'b00;
  end
  // slow toggle so the synchroniser never misses a level
  always @(posedge clk) begin
    div <= div + 2'b01;
    external_tick_pin <= div[1];
  end
  // set a level; a nonzero hold returns it after that many cycles
  task automatic pulse(input logic cmp, input logic v, input int hold);
    @(posedge clk);
    if (cmp) comparator_output <= v;
    else capture_pin <= v;
    if (hold > 0) begin
      repeat (hold) @(posedge clk);
      if (cmp) comparator_output <= !v;
      else capture_pin <= !v;
    end
  endtask
endmodule
